// [src/ddclm_pkg.sv]
// Purpose: Constants shared by the decimation and link mode register bank.
// Assumes: 24-bit serial frame, register data 8 bits wide.
// Notes: Page codes of the two link pages are free parameters of the map.
package ddclm_pkg;

  // ------------------------------------------------------------------
  // Serial frame layout
  // ------------------------------------------------------------------
  localparam logic [4:0] LAST_CMD_BIT = 5'h0F;
  localparam logic [4:0] LAST_FRAME_BIT = 5'h17;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam int RW_POS = 23;
  localparam int BANK_POS = 22;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 8;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } ddclm_phase_t;

  // ------------------------------------------------------------------
  // General registers and page codes
  // ------------------------------------------------------------------
  localparam logic [11:0] GEN_RESET = 12'h000;
  localparam logic [11:0] GEN_DPAGE_LO = 12'h003;
  localparam logic [11:0] GEN_DPAGE_HI = 12'h004;
  localparam logic [11:0] GEN_APAGE = 12'h011;
  localparam logic [11:0] GEN_LIMIT = 12'h020;
  localparam int SOFT_RST_BIT = 0;
  localparam logic [15:0] PAGE_MAIN_DIG = 16'h6800;
  localparam logic [15:0] PAGE_LINK_DIG = 16'h6900;
  localparam logic [15:0] PAGE_LINK_ANA = 16'h6A00;
  localparam logic [7:0] APAGE_MASTER = 8'h80;
  localparam logic [7:0] APAGE_CONV = 8'h0F;

  // ------------------------------------------------------------------
  // Configuration registers: offset, index, writable bits, reset value
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_FORMAT = 12'h001;
  localparam logic [11:0] OFS_SHARE = 12'h016;
  localparam logic [11:0] OFS_CMUL = 12'h016;
  localparam logic [11:0] OFS_ORDER_A = 12'h031;
  localparam logic [11:0] OFS_ORDER_B = 12'h032;
  localparam logic [11:0] OFS_FMODE = 12'h041;
  localparam logic [11:0] OFS_DPATH = 12'h04D;
  localparam logic [11:0] OFS_REN1 = 12'h052;
  localparam logic [11:0] OFS_REN2 = 12'h072;
  localparam int NUM_REGS = 9;
  localparam logic [3:0] IDX_FORMAT = 4'h0;
  localparam logic [3:0] IDX_SHARE = 4'h1;
  localparam logic [3:0] IDX_CMUL = 4'h2;
  localparam logic [3:0] IDX_ORDER_A = 4'h3;
  localparam logic [3:0] IDX_ORDER_B = 4'h4;
  localparam logic [3:0] IDX_FMODE = 4'h5;
  localparam logic [3:0] IDX_DPATH = 4'h6;
  localparam logic [3:0] IDX_REN1 = 4'h7;
  localparam logic [3:0] IDX_REN2 = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;
  // Index 8 first, index 0 last
  localparam logic [8:0][7:0] REG_MASK = {8'h08, 8'h80, 8'h08, 8'h37,
    8'hFF, 8'hFF, 8'h03, 8'h10, 8'h3F};
  localparam logic [8:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  // ------------------------------------------------------------------
  // Field positions and codes
  // ------------------------------------------------------------------
  localparam int DPATH_BIT = 3;
  localparam int FEN_BIT = 4;
  localparam int FM_HI_BIT = 5;
  localparam int SHARE_BIT = 4;
  localparam int REN1_BIT = 7;
  localparam int REN2_BIT = 3;
  localparam logic [2:0] LF_NONE = 3'b000;
  localparam logic [2:0] LF_2X = 3'b110;
  localparam logic [2:0] LF_R4X = 3'b100;
  localparam logic [2:0] LF_C4X = 3'b111;
  localparam logic [2:0] FMT_1OCT = 3'b100;
  localparam logic [2:0] FMT_4OCT = 3'b010;
  localparam logic [2:0] FMT_2OCT = 3'b001;
  localparam logic [1:0] CMUL_HI = 2'b10;
  localparam logic [1:0] CMUL_LO = 2'b00;
  localparam logic [3:0] FM_C4X = 4'b0011;
  localparam logic [3:0] FM_LPF = 4'b0010;
  localparam logic [3:0] FM_HPF = 4'b0110;
  localparam logic [1:0] FM_BPF_LOW = 2'b00;
  localparam logic [7:0] ORDER_DEC = 8'h0A;
  localparam logic [7:0] ORDER_OFF = 8'h00;

endpackage : ddclm_pkg

// [src/ddclm_regbank.sv]
// Purpose: Serial-port register bank for decimation and link lane setup.
// Assumes: Serial pins are synchronous to core_clk_i and slower than it.
// Notes: Frame is read flag, bank flag, two spare bits, address, data.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1 - Path and filter enables clear when undecimated, set when decimating.
// R2 - Filter mode: 0011 complex 4X, 0010/0110 for 2X, xx00 real 4X.
// R3 - Link filter: 000 none, 110 2X, 100 real 4X, 111 complex 4X.
// R4 - Link mode: 100 four-lane one-octet, 010 four-octet, 001 two-octet.
// R5 - Clock multiplier mode: 10 for one- and four-octet, 00 for two-octet.
// R6 - Lane merge bit set only in single-lane real 4X mode.
// R7 - Channel A order byte 0Ah when decimating, 00h otherwise.
// R8 - Channel B order byte 0Ah when decimating, 00h otherwise.
// R9 - First order enable set when decimating, clear otherwise.
// R10 - Second order enable set when decimating, clear otherwise.
// R11 - Two banks: analog for converter blocks, digital for engine and link.
// R12 - Analog bank has two pages, digital bank three, page chosen first.
// R13 - Host writes one whole consistent configuration, never a mixture.
module ddclm_regbank
  import ddclm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sen_n_i,
  input wire logic spi_sdin_i,
  output logic spi_sdout_o,
  output logic decimation_path_enable_o,
  output logic filter_enable_o,
  output logic [3:0] filter_mode_select_o,
  output logic [2:0] link_filter_select_o,
  output logic [2:0] link_format_mode_o,
  output logic [1:0] link_clock_mult_mode_o,
  output logic single_lane_merge_o,
  output logic [7:0] chan_a_order_code_o,
  output logic [7:0] chan_b_order_code_o,
  output logic order_enable_first_o,
  output logic order_enable_second_o,
  output logic config_valid_o
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic [3:0] ddclm_decode(input logic dig,
      input logic [15:0] dpage, input logic [11:0] addr);
    logic [3:0] idx;
    idx = IDX_NONE;
    if (dig && dpage == PAGE_MAIN_DIG) begin
      case (addr)
        OFS_FMODE: idx = IDX_FMODE;
        OFS_DPATH: idx = IDX_DPATH;
        OFS_REN1: idx = IDX_REN1;
        OFS_REN2: idx = IDX_REN2;
        default: idx = IDX_NONE;
      endcase
    end else if (dig && dpage == PAGE_LINK_DIG) begin
      case (addr)
        OFS_FORMAT: idx = IDX_FORMAT;
        OFS_SHARE: idx = IDX_SHARE;
        OFS_ORDER_A: idx = IDX_ORDER_A;
        OFS_ORDER_B: idx = IDX_ORDER_B;
        default: idx = IDX_NONE;
      endcase
    end else if (dig && dpage == PAGE_LINK_ANA && addr == OFS_CMUL) begin
      idx = IDX_CMUL;
    end
    return idx;
  endfunction : ddclm_decode

  // ------------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------------
  ddclm_phase_t phase_q, phase_d;
  logic sclk_prev_q;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [23:0] shift_q, shift_d;
  logic [7:0] rd_shift_q, rd_shift_d;
  logic sdout_q, sdout_d;
  logic [15:0] dpage_q, dpage_d;
  logic [7:0] apage_q, apage_d;
  logic [7:0] regs_q [NUM_REGS];
  logic cfg_ok_q;

  wire sclk_rise = spi_sclk_i && !sclk_prev_q && !spi_sen_n_i;
  wire sclk_fall = !spi_sclk_i && sclk_prev_q && !spi_sen_n_i;
  wire [23:0] frame = {shift_q[22:0], spi_sdin_i};
  wire cmd_done = sclk_rise && bit_cnt_q == LAST_CMD_BIT;
  wire frame_done = sclk_rise && bit_cnt_q == LAST_FRAME_BIT;
  wire is_read = frame[RW_POS - 8];
  wire wr_commit = frame_done && !frame[RW_POS];
  wire dig_bank = frame[BANK_POS];
  wire [11:0] cmd_addr = frame[ADDR_HI - 8:ADDR_LO - 8];
  wire [11:0] wr_addr = frame[ADDR_HI:ADDR_LO];
  wire [7:0] wr_data = frame[7:0];
  wire wr_dig = frame[BANK_POS];
  wire rd_dig = frame[BANK_POS - 8];

  // General registers answer only with the bank flag clear, below GEN_LIMIT
  wire rd_gen = !rd_dig && cmd_addr < GEN_LIMIT;
  wire wr_gen = !wr_dig && wr_addr < GEN_LIMIT;
  // Analog pages hold no register of this bank; they read as zero
  wire [3:0] rd_idx = ddclm_decode(rd_dig, dpage_q, cmd_addr); // R11 R12
  wire [3:0] wr_idx = ddclm_decode(wr_dig, dpage_q, wr_addr); // R11 R12
  wire soft_rst = wr_commit && wr_gen && wr_addr == GEN_RESET &&
    wr_data[SOFT_RST_BIT];

  logic [7:0] gen_rdata;
  always_comb begin
    case (cmd_addr)
      GEN_DPAGE_LO: gen_rdata = dpage_q[7:0];
      GEN_DPAGE_HI: gen_rdata = dpage_q[15:8];
      GEN_APAGE: gen_rdata = apage_q;
      default: gen_rdata = 8'h00;
    endcase
  end

  wire [7:0] reg_rdata = (rd_idx == IDX_NONE) ? 8'h00 : regs_q[rd_idx];
  wire [7:0] rd_data = rd_gen ? gen_rdata : reg_rdata;

  always_comb begin
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    rd_shift_d = rd_shift_q;
    sdout_d = sdout_q;
    case (phase_q)
      PH_IDLE: begin
        bit_cnt_d = 5'h00;
        if (!spi_sen_n_i) begin
          phase_d = PH_CMD;
        end
      end
      PH_CMD: begin
        if (sclk_rise) begin
          shift_d = frame;
          bit_cnt_d = bit_cnt_q + CNT_STEP;
        end
        if (cmd_done) begin
          phase_d = PH_DATA;
          rd_shift_d = is_read ? rd_data : 8'h00;
        end
      end
      PH_DATA: begin
        if (sclk_rise) begin
          shift_d = frame;
          bit_cnt_d = bit_cnt_q + CNT_STEP;
        end
        // Read data leaves on falling edges so the host samples on rising
        if (sclk_fall) begin
          sdout_d = rd_shift_q[7];
          rd_shift_d = {rd_shift_q[6:0], 1'b0};
        end
        if (frame_done) begin
          phase_d = PH_IDLE;
        end
      end
      default: phase_d = PH_IDLE;
    endcase
    // Deselect aborts a partial frame without any register effect
    if (spi_sen_n_i) begin
      phase_d = PH_IDLE;
      sdout_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_q <= PH_IDLE;
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      shift_q <= 24'h000000;
      rd_shift_q <= 8'h00;
      sdout_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      sclk_prev_q <= spi_sclk_i;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      rd_shift_q <= rd_shift_d;
      sdout_q <= sdout_d;
    end
  end

  // ------------------------------------------------------------------
  // Page selects and configuration storage
  // ------------------------------------------------------------------
  always_comb begin
    dpage_d = dpage_q;
    apage_d = apage_q;
    if (wr_commit && wr_gen) begin
      if (wr_addr == GEN_DPAGE_LO) dpage_d[7:0] = wr_data; // R12
      if (wr_addr == GEN_DPAGE_HI) dpage_d[15:8] = wr_data; // R12
      if (wr_addr == GEN_APAGE) apage_d = wr_data; // R12
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dpage_q <= 16'h0000;
      apage_q <= 8'h00;
    end else begin
      dpage_q <= dpage_d;
      apage_q <= apage_d;
    end
  end

  // Masking keeps reserved bits at zero on read-back
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || soft_rst) begin
        regs_q[g] <= REG_RESET[g];
      end else if (wr_commit && wr_idx == 4'(g)) begin
        regs_q[g] <= wr_data & REG_MASK[g];
      end
    end
  end

  // ------------------------------------------------------------------
  // Field outputs
  // ------------------------------------------------------------------
  assign spi_sdout_o = sdout_q;
  assign decimation_path_enable_o = regs_q[IDX_DPATH][DPATH_BIT]; // R1
  assign filter_enable_o = regs_q[IDX_FMODE][FEN_BIT]; // R1
  assign filter_mode_select_o = {regs_q[IDX_FMODE][FM_HI_BIT],
    regs_q[IDX_FMODE][2:0]}; // R2
  assign link_filter_select_o = regs_q[IDX_FORMAT][5:3]; // R3
  assign link_format_mode_o = regs_q[IDX_FORMAT][2:0]; // R4
  assign link_clock_mult_mode_o = regs_q[IDX_CMUL][1:0]; // R5
  assign single_lane_merge_o = regs_q[IDX_SHARE][SHARE_BIT]; // R6
  assign chan_a_order_code_o = regs_q[IDX_ORDER_A]; // R7
  assign chan_b_order_code_o = regs_q[IDX_ORDER_B]; // R8
  assign order_enable_first_o = regs_q[IDX_REN1][REN1_BIT]; // R9
  assign order_enable_second_o = regs_q[IDX_REN2][REN2_BIT]; // R10

  // ------------------------------------------------------------------
  // Consistency of the whole configuration
  // ------------------------------------------------------------------
  // Flags a mixture; the bank still applies it, so firmware must not
  // rely on this to block a half-written setup.
  wire dec_on = decimation_path_enable_o && filter_enable_o; // R1
  wire dec_off = !decimation_path_enable_o && !filter_enable_o; // R1
  wire fmt_2oct = link_format_mode_o == FMT_2OCT &&
    link_clock_mult_mode_o == CMUL_LO; // R4 R5
  wire fmt_4oct = link_format_mode_o == FMT_4OCT &&
    link_clock_mult_mode_o == CMUL_HI; // R4 R5
  wire fmt_1oct = link_format_mode_o == FMT_1OCT &&
    link_clock_mult_mode_o == CMUL_HI; // R4 R5
  wire order_dec = chan_a_order_code_o == ORDER_DEC &&
    chan_b_order_code_o == ORDER_DEC && order_enable_first_o &&
    order_enable_second_o; // R7 R8 R9 R10
  wire order_off = chan_a_order_code_o == ORDER_OFF &&
    chan_b_order_code_o == ORDER_OFF && !order_enable_first_o &&
    !order_enable_second_o; // R7 R8 R9 R10
  wire mode_c4x = filter_mode_select_o == FM_C4X &&
    link_filter_select_o == LF_C4X; // R2 R3
  wire mode_2x = (filter_mode_select_o == FM_LPF ||
    filter_mode_select_o == FM_HPF) && link_filter_select_o == LF_2X;
  wire mode_r4x = filter_mode_select_o[1:0] == FM_BPF_LOW &&
    link_filter_select_o == LF_R4X; // R2 R3
  wire share_ok = !single_lane_merge_o || (mode_r4x && fmt_4oct); // R6
  wire cfg_nodec = dec_off && order_off && link_filter_select_o == LF_NONE &&
    !single_lane_merge_o && (fmt_1oct || fmt_2oct || fmt_4oct);
  wire cfg_dec = dec_on && order_dec && share_ok &&
    (mode_c4x || mode_2x || mode_r4x) && (fmt_2oct || fmt_4oct);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_ok_q <= 1'b0;
    end else begin
      cfg_ok_q <= cfg_nodec || cfg_dec; // R13
    end
  end
  assign config_valid_o = cfg_ok_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_r1;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    config_valid_o |-> $past(decimation_path_enable_o) ==
      $past(filter_enable_o);
  endproperty
  a_r1: assert property (p_r1) else $error("enables disagree"); // R1

  property p_r2;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && $past(link_filter_select_o) == LF_C4X) |->
      $past(filter_mode_select_o) == FM_C4X;
  endproperty
  a_r2: assert property (p_r2) else $error("complex mode code"); // R2

  property p_r3;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && !$past(decimation_path_enable_o)) |->
      $past(link_filter_select_o) == LF_NONE;
  endproperty
  a_r3: assert property (p_r3) else $error("link filter set"); // R3

  property p_r4;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && $past(link_format_mode_o) == FMT_1OCT) |->
      !$past(decimation_path_enable_o);
  endproperty
  a_r4: assert property (p_r4) else $error("one-octet decimating"); // R4

  property p_r5;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && $past(link_format_mode_o) == FMT_2OCT) |->
      $past(link_clock_mult_mode_o) == CMUL_LO;
  endproperty
  a_r5: assert property (p_r5) else $error("clock mode mismatch"); // R5

  property p_r6;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && $past(single_lane_merge_o)) |->
      $past(link_filter_select_o) == LF_R4X;
  endproperty
  a_r6: assert property (p_r6) else $error("merge outside real 4X"); // R6

  property p_r7;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && $past(decimation_path_enable_o)) |->
      $past(chan_a_order_code_o) == ORDER_DEC;
  endproperty
  a_r7: assert property (p_r7) else $error("order A wrong"); // R7

  property p_r8;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_valid_o && !$past(decimation_path_enable_o)) |->
      $past(chan_b_order_code_o) == ORDER_OFF;
  endproperty
  a_r8: assert property (p_r8) else $error("order B wrong"); // R8

  property p_r9;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    config_valid_o |-> $past(order_enable_first_o) ==
      $past(decimation_path_enable_o);
  endproperty
  a_r9: assert property (p_r9) else $error("first enable wrong"); // R9

  property p_r10;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_commit && wr_idx == IDX_REN2 && !soft_rst) |=>
      order_enable_second_o == $past(wr_data[REN2_BIT]);
  endproperty
  a_r10: assert property (p_r10) else $error("second enable lost"); // R10

  property p_r12;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_commit && wr_dig && dpage_q != PAGE_LINK_DIG &&
      dpage_q != PAGE_MAIN_DIG && dpage_q != PAGE_LINK_ANA) |=>
      $stable(link_format_mode_o) && $stable(filter_mode_select_o);
  endproperty
  a_r12: assert property (p_r12) else $error("write without page"); // R12

  property p_r11;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_commit && !wr_dig && !soft_rst) |=> $stable(chan_a_order_code_o);
  endproperty
  a_r11: assert property (p_r11) else $error("analog bank hit link"); // R11

endmodule : ddclm_regbank

`default_nettype wire

// [verif/ddclm_host_model.sv]
// Purpose: Serial host that sends 24-bit register frames to the bank.
// Assumes: Serial clock is made from core_clk_i, three core cycles a phase.
// Notes: Serial clock rests low between frames; the data line is driven to the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none

module ddclm_host_model (
  input wire logic core_clk_i,
  input wire logic spi_sdout_i,
  output logic spi_sclk_o,
  output logic spi_sen_n_o,
  output logic spi_sdin_o
);
  localparam int HALF = 3;

  initial begin
    spi_sclk_o = 1'b0;
    spi_sen_n_o = 1'b1;
    spi_sdin_o = 1'b0;
  end

  // ------------------------------------------------------------------
  // One frame; fewer than 24 bits aborts it by raising select early
  // ------------------------------------------------------------------
  task automatic xfer(input logic [23:0] fr, input int nbits,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk_i);
    spi_sen_n_o <= 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      @(posedge core_clk_i);
      spi_sclk_o <= 1'b0;
      spi_sdin_o <= fr[i];
      repeat (HALF) @(posedge core_clk_i);
      // Read bit settles one edge after the fall, sampled before rise
      if (i < 8) rd[i] = spi_sdout_i;
      spi_sclk_o <= 1'b1;
      repeat (HALF - 1) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    spi_sclk_o <= 1'b0;
    spi_sen_n_o <= 1'b1;
    // Inverted line must not keep showing the last bit
    spi_sdin_o <= ~spi_sdin_o;
  endtask : xfer

endmodule : ddclm_host_model

`default_nettype wire

// [verif/tb_ddc_link_mode_config.sv]
// Purpose: Self-checking bench for the decimation and link mode bank.
// Assumes: Host model drives the serial port; seeded random filter codes.
// Notes: Expected fields are derived from the mode table, not the outputs.
`timescale 1ns/1ps
`default_nettype none

module tb_ddc_link_mode_config;
  import ddclm_pkg::*;

  logic core_clk;
  logic rst_n;
  wire logic sclk;
  wire logic sen_n;
  wire logic sdin;
  logic sdout, dpe, fen, share, oen1, oen2, cvalid;
  logic [3:0] fmode;
  logic [2:0] lfilt, lfmt;
  logic [1:0] cmul;
  logic [7:0] ord_a, ord_b, rdv;
  int err_total = 0;
  int compares = 0;
  int cls_tab[9] = '{0, 0, 0, 1, 2, 2, 3, 1, 3};
  logic [2:0] fmt_tab[9] = '{FMT_1OCT, FMT_4OCT, FMT_2OCT, FMT_2OCT,
    FMT_2OCT, FMT_4OCT, FMT_2OCT, FMT_4OCT, FMT_4OCT};

  ddclm_host_model host (.core_clk_i(core_clk), .spi_sdout_i(sdout),
    .spi_sclk_o(sclk), .spi_sen_n_o(sen_n), .spi_sdin_o(sdin));

  ddclm_regbank DUT (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .spi_sclk_i(sclk), .spi_sen_n_i(sen_n), .spi_sdin_i(sdin),
    .spi_sdout_o(sdout), .decimation_path_enable_o(dpe),
    .filter_enable_o(fen), .filter_mode_select_o(fmode),
    .link_filter_select_o(lfilt), .link_format_mode_o(lfmt),
    .link_clock_mult_mode_o(cmul), .single_lane_merge_o(share),
    .chan_a_order_code_o(ord_a), .chan_b_order_code_o(ord_b),
    .order_enable_first_o(oen1), .order_enable_second_o(oen2),
    .config_valid_o(cvalid));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Mode table helpers
  // ------------------------------------------------------------------
  function automatic logic [2:0] lf_of(int c);
    case (c)
      1: return LF_C4X;
      2: return LF_2X;
      3: return LF_R4X;
      default: return LF_NONE;
    endcase
  endfunction : lf_of

  function automatic logic [1:0] cm_of(logic [2:0] f);
    return (f == FMT_2OCT) ? CMUL_LO : CMUL_HI;
  endfunction : cm_of

  function automatic logic sh_of(int c, logic [2:0] f);
    return (c == 3) && (f == FMT_4OCT);
  endfunction : sh_of

  function automatic logic [3:0] pick_fm(int c);
    logic [1:0] r;
    r = 2'($urandom);
    case (c)
      1: return FM_C4X;
      2: return r[0] ? FM_HPF : FM_LPF;
      3: return {r, FM_BPF_LOW};
      default: return 4'h0;
    endcase
  endfunction : pick_fm

  // ------------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic bk, input logic [11:0] a,
                    input logic [7:0] d);
    host.xfer({1'b0, bk, 2'b00, a, d}, 24, rdv);
  endtask : wr

  task automatic rd(input logic bk, input logic [11:0] a);
    host.xfer({1'b1, bk, 2'b00, a, 8'h00}, 24, rdv);
  endtask : rd

  task automatic page(input logic [15:0] p);
    wr(1'b0, GEN_DPAGE_LO, p[7:0]);
    wr(1'b0, GEN_DPAGE_HI, p[15:8]);
  endtask : page

  task automatic apply_row(input int c, input logic [2:0] f,
                           input logic [3:0] fm);
    logic dec;
    dec = (c != 0);
    page(PAGE_MAIN_DIG);
    wr(1'b1, OFS_FMODE, {2'b00, fm[3], dec, 1'b0, fm[2:0]});
    wr(1'b1, OFS_DPATH, {4'h0, dec, 3'h0});
    wr(1'b1, OFS_REN1, {dec, 7'h00});
    wr(1'b1, OFS_REN2, {4'h0, dec, 3'h0});
    page(PAGE_LINK_DIG);
    wr(1'b1, OFS_FORMAT, {2'b00, lf_of(c), f});
    wr(1'b1, OFS_SHARE, {3'h0, sh_of(c, f), 4'h0});
    wr(1'b1, OFS_ORDER_A, dec ? ORDER_DEC : ORDER_OFF);
    wr(1'b1, OFS_ORDER_B, dec ? ORDER_DEC : ORDER_OFF);
    page(PAGE_LINK_ANA);
    wr(1'b1, OFS_CMUL, {6'h00, cm_of(f)});
  endtask : apply_row

  task automatic check_row(input int c, input logic [2:0] f,
                           input logic [3:0] fm);
    logic dec;
    dec = (c != 0);
    repeat (3) @(posedge core_clk);
    chk({7'h00, dpe}, {7'h00, dec});
    chk({7'h00, fen}, {7'h00, dec});
    chk({4'h0, fmode}, {4'h0, fm});
    chk({5'h00, lfilt}, {5'h00, lf_of(c)});
    chk({5'h00, lfmt}, {5'h00, f});
    chk({6'h00, cmul}, {6'h00, cm_of(f)});
    chk({7'h00, share}, {7'h00, sh_of(c, f)});
    chk(ord_a, dec ? ORDER_DEC : ORDER_OFF);
    chk(ord_b, dec ? ORDER_DEC : ORDER_OFF);
    chk({7'h00, oen1}, {7'h00, dec});
    chk({7'h00, oen2}, {7'h00, dec});
    chk({7'h00, cvalid}, 8'h01);
  endtask : check_row

  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    results();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int r;
    logic [3:0] fm;
    rst_n = 1'b0;
    void'($urandom(32'h859B));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check_row(0 + 2 * 0, FMT_2OCT, 4'h0);
    // No page selected yet, so a link write must be dropped
    wr(1'b1, OFS_FORMAT, 8'h3A);
    check_row(0, FMT_2OCT, 4'h0);
    for (int i = 0; i < 15; i++) begin
      r = (i < 9) ? i : int'($urandom_range(8, 0));
      fm = pick_fm(cls_tab[r]);
      apply_row(cls_tab[r], fmt_tab[r], fm);
      check_row(cls_tab[r], fmt_tab[r], fm);
      page(PAGE_LINK_DIG);
      rd(1'b1, OFS_FORMAT);
      chk(rdv, {2'b00, lf_of(cls_tab[r]), fmt_tab[r]});
    end
    // Aborted frame and analog-bank frame leave the link setup alone
    host.xfer({1'b0, 1'b1, 2'b00, OFS_ORDER_A, 8'h55}, 12, rdv);
    wr(1'b0, OFS_ORDER_A, 8'h55);
    rd(1'b1, OFS_ORDER_A);
    chk(rdv, (cls_tab[r] != 0) ? ORDER_DEC : ORDER_OFF);
    // Mixed settings are stored but flagged
    apply_row(1, FMT_2OCT, FM_C4X);
    page(PAGE_LINK_DIG);
    wr(1'b1, OFS_FORMAT, {2'b00, LF_C4X, FMT_4OCT});
    repeat (3) @(posedge core_clk);
    chk({5'h00, lfmt}, {5'h00, FMT_4OCT});
    chk({7'h00, cvalid}, 8'h00);
    page(PAGE_MAIN_DIG);
    rd(1'b1, 12'h060);
    chk(rdv, 8'h00);
    wr(1'b1, OFS_DPATH, 8'hFF);
    rd(1'b1, OFS_DPATH);
    chk(rdv, 8'h08);
    wr(1'b0, GEN_APAGE, APAGE_CONV);
    rd(1'b0, GEN_APAGE);
    chk(rdv, APAGE_CONV);
    wr(1'b0, GEN_RESET, 8'h01);
    check_row(0, FMT_2OCT, 4'h0);
    // Soft reset restores the fields but keeps the page selects
    rd(1'b0, GEN_DPAGE_HI);
    chk(rdv, PAGE_MAIN_DIG[15:8]);
    results();
  end

endmodule : tb_ddc_link_mode_config

`default_nettype wire
